// ---- rtl/tcd_device.sv ----
// The register addresses and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
// Functional notes
// - Host sends command before buffer payload
// - Two command words, A then B
// - Host sends both words every buffer
// - Host repeats identical B per packet
// - B mismatch raises transmit error
// - B carries free 16-bit packet tag
// - Tag copied into packet status
// - A bit 31 raises buffer-done flag
// - Buffer-done maskable onto interrupt
// - Host zeroes reserved A bits
// - A 25:24 selects end alignment
// - Host pads buffer to alignment
// - Alignment padding words are discarded
// - A 20:16 skips leading bytes
// - A bit 13 first, 12 last
// - Summed sizes must equal packet length
// - B 10:0 is packet length
module tcd_device (
  input wire logic clk_sys,
  input wire logic sys_rst,
  tcd_if.dev link,
  input wire logic done_irq_en,
  input wire logic done_clr,
  input wire logic err_clr
);
  typedef struct packed {
    tcd_pkg::tcd_phase_t phase;
    logic ioc;
    logic [4:0] align_words;
    logic [11:0] skip;
    logic [11:0] left;
    logic [4:0] words;
    logic [31:0] b_lat;
    logic in_pkt;
    logic last;
    logic [11:0] sum;
    logic err;
    logic done;
    logic irq;
    logic stat_valid;
    logic [15:0] stat_tag;
    logic [31:0] pay_data;
    logic [3:0] pay_be;
    logic pay_valid;
  } tcd_dev_st_t;

  tcd_dev_st_t s_r, s_nxt;
  logic [3:0] be;
  logic [2:0] cnt;
  logic [31:0] w;

  function automatic logic [4:0] align_words_f(input logic [1:0] code);
    case (code)
      tcd_pkg::ALIGN_16: align_words_f = 5'h04;
      tcd_pkg::ALIGN_32: align_words_f = 5'h08;
      default: align_words_f = 5'h01;
    endcase
  endfunction

  assign w = link.wdata;

  tcd_lane_mask u_mask (
    .skip(s_r.skip),
    .left(s_r.left),
    .be(be),
    .cnt(cnt)
  );

  always_comb begin
    s_nxt = s_r;
    s_nxt.stat_valid = 1'b0;
    s_nxt.pay_valid = 1'b0;
    if (done_clr) s_nxt.done = 1'b0;
    if (err_clr) s_nxt.err = 1'b0;
    if (link.wvalid) begin
      case (s_r.phase)
        tcd_pkg::TCD_CMD_A: begin
          s_nxt.ioc = w[tcd_pkg::A_IOC_BIT];
          s_nxt.align_words = align_words_f(w[tcd_pkg::A_ALIGN_HI:tcd_pkg::A_ALIGN_LO]);
          s_nxt.skip = {7'h00, w[tcd_pkg::A_OFS_HI:tcd_pkg::A_OFS_LO]};
          s_nxt.left = {1'b0, w[tcd_pkg::A_SIZE_HI:0]};
          s_nxt.last = w[tcd_pkg::A_LAST_BIT];
          s_nxt.words = 5'h00;
          if (w[tcd_pkg::A_FIRST_BIT]) begin
            s_nxt.in_pkt = 1'b0;
            s_nxt.sum = 12'h000;
          end
          s_nxt.sum = (w[tcd_pkg::A_FIRST_BIT] ? 12'h000 : s_r.sum) + {1'b0, w[tcd_pkg::A_SIZE_HI:0]};
          s_nxt.phase = tcd_pkg::TCD_CMD_B;
        end
        tcd_pkg::TCD_CMD_B: begin
          if (!s_r.in_pkt) begin
            s_nxt.b_lat = w;
            s_nxt.in_pkt = 1'b1;
          end else if (w != s_r.b_lat) begin
            s_nxt.err = 1'b1;
          end
          s_nxt.phase = tcd_pkg::TCD_DATA;
        end
        default: begin
          // Padding words fall through with no byte enables
          if (be != 4'h0) begin
            s_nxt.pay_valid = 1'b1;
            s_nxt.pay_data = w;
            s_nxt.pay_be = be;
          end
          s_nxt.skip = (s_r.skip > 12'h004) ? s_r.skip - 12'h004 : 12'h000;
          s_nxt.left = s_r.left - {9'h000, cnt};
          s_nxt.words = s_r.words + 5'h01;
          if (s_nxt.left == 12'h000 && s_nxt.skip == 12'h000 &&
              ((s_r.words + 5'h01) & (s_r.align_words - 5'h01)) == 5'h00) begin
            s_nxt.phase = tcd_pkg::TCD_CMD_A;
            if (s_r.ioc) s_nxt.done = 1'b1;
            if (s_r.last) begin
              s_nxt.in_pkt = 1'b0;
              s_nxt.stat_valid = 1'b1;
              s_nxt.stat_tag = s_r.b_lat[tcd_pkg::B_TAG_HI:tcd_pkg::B_TAG_LO];
              if (s_r.sum != {1'b0, s_r.b_lat[tcd_pkg::B_LEN_HI:0]}) s_nxt.err = 1'b1;
            end
          end
        end
      endcase
    end
    s_nxt.irq = s_nxt.done & done_irq_en;
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) s_r <= '0;
    else s_r <= s_nxt;
  end

  assign link.wready = 1'b1;
  assign link.tx_error = s_r.err;
  assign link.buf_done = s_r.done;
  assign link.irq = s_r.irq;
  assign link.stat_valid = s_r.stat_valid;
  assign link.stat_tag = s_r.stat_tag;
  assign link.pay_data = s_r.pay_data;
  assign link.pay_be = s_r.pay_be;
  assign link.pay_valid = s_r.pay_valid;
endmodule

// ---- include/tcd_pkg.sv ----
package tcd_pkg;
  // Command word A fields
  localparam int A_IOC_BIT = 31;
  localparam int A_ALIGN_HI = 25;
  localparam int A_ALIGN_LO = 24;
  localparam int A_OFS_HI = 20;
  localparam int A_OFS_LO = 16;
  localparam int A_FIRST_BIT = 13;
  localparam int A_LAST_BIT = 12;
  localparam int A_SIZE_HI = 10;
  // Command word B fields
  localparam int B_TAG_HI = 31;
  localparam int B_TAG_LO = 16;
  localparam int B_LEN_HI = 10;
  // Alignment codes
  localparam logic [1:0] ALIGN_4 = 2'h0;
  localparam logic [1:0] ALIGN_16 = 2'h1;
  localparam logic [1:0] ALIGN_32 = 2'h2;
  // Host command register map (byte addresses)
  localparam logic [7:0] REG_DATA = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_CTRL = 8'h08;
  localparam logic [7:0] REG_TAG = 8'h0c;
  // Status / control bit positions
  localparam int ST_ERR_BIT = 0;
  localparam int ST_DONE_BIT = 1;
  localparam int ST_BUSY_BIT = 2;
  localparam int CTRL_DONE_EN_BIT = 0;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  typedef enum logic [1:0] {
    TCD_CMD_A = 2'b00,
    TCD_CMD_B = 2'b01,
    TCD_DATA = 2'b10
  } tcd_phase_t;
endpackage

// ---- include/tcd_if.sv ----
`timescale 1ns/1ps
interface tcd_if;
  logic [31:0] wdata;
  logic wvalid;
  logic wready;
  logic tx_error;
  logic buf_done;
  logic irq;
  logic stat_valid;
  logic [15:0] stat_tag;
  logic [31:0] pay_data;
  logic [3:0] pay_be;
  logic pay_valid;
  modport dev (input wdata, input wvalid, output wready, output tx_error, output buf_done, output irq,
    output stat_valid, output stat_tag, output pay_data, output pay_be, output pay_valid);
  modport hst (output wdata, output wvalid, input wready, input tx_error, input buf_done, input irq,
    input stat_valid, input stat_tag, input pay_data, input pay_be, input pay_valid);
endinterface

// ---- rtl/tcd_lane_mask.sv ----
`timescale 1ns/1ps
module tcd_lane_mask (
  input wire logic [11:0] skip,
  input wire logic [11:0] left,
  output logic [3:0] be,
  output logic [2:0] cnt
);
  always_comb begin
    be = 4'h0;
    cnt = 3'h0;
    for (int i = 0; i < 4; i++) begin
      if (12'(i) >= skip && 12'(i) < skip + left) begin
        be[i] = 1'b1;
        cnt = cnt + 3'h1;
      end
    end
  end
endmodule

// ---- rtl/tcd_host.sv ----
`timescale 1ns/1ps
module tcd_host (
  input wire logic clk_sys,
  input wire logic sys_rst,
  tcd_if.hst link,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic hsel,
  input wire logic hready,
  input wire logic [31:0] hwdata,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  output logic done_irq_en,
  output logic done_clr,
  output logic err_clr
);
  typedef struct packed {
    logic ph_wr;
    logic [7:0] ph_addr;
    logic [31:0] wdata;
    logic wvalid;
    logic [31:0] ctrl;
    logic [15:0] tag;
    logic [31:0] rdata;
    logic dclr;
    logic eclr;
  } tcd_host_st_t;

  tcd_host_st_t s_r, s_nxt;

  // Words go to the device in write order, so command words land before payload
  always_comb begin
    s_nxt = s_r;
    s_nxt.wvalid = 1'b0;
    s_nxt.dclr = 1'b0;
    s_nxt.eclr = 1'b0;
    if (s_r.ph_wr) begin
      case (s_r.ph_addr)
        tcd_pkg::REG_DATA: begin
          s_nxt.wdata = hwdata;
          s_nxt.wvalid = 1'b1;
        end
        tcd_pkg::REG_STATUS: begin
          s_nxt.eclr = hwdata[tcd_pkg::ST_ERR_BIT];
          s_nxt.dclr = hwdata[tcd_pkg::ST_DONE_BIT];
        end
        tcd_pkg::REG_CTRL: s_nxt.ctrl = hwdata;
        default: ;
      endcase
    end
    if (link.stat_valid) s_nxt.tag = link.stat_tag;
    s_nxt.ph_wr = hsel && hready && htrans[1] && hwrite;
    s_nxt.ph_addr = haddr[7:0];
    if (hsel && hready && htrans[1] && !hwrite) begin
      case (haddr[7:0])
        tcd_pkg::REG_STATUS: s_nxt.rdata = {29'h0, 1'b0, link.buf_done, link.tx_error};
        tcd_pkg::REG_CTRL: s_nxt.rdata = s_r.ctrl;
        tcd_pkg::REG_TAG: s_nxt.rdata = {16'h0000, s_r.tag};
        default: s_nxt.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (sys_rst) begin
      s_r <= '0;
      s_r.ctrl <= tcd_pkg::CTRL_RST;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign link.wdata = s_r.wdata;
  assign link.wvalid = s_r.wvalid;
  assign hrdata = s_r.rdata;
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign done_irq_en = s_r.ctrl[tcd_pkg::CTRL_DONE_EN_BIT];
  assign done_clr = s_r.dclr;
  assign err_clr = s_r.eclr;
endmodule

// ---- dv/tcd_check_sva.sv ----
`timescale 1ns/1ps
module tcd_check_sva (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic tx_error,
  input wire logic buf_done,
  input wire logic irq,
  input wire logic stat_valid,
  input wire logic [15:0] stat_tag,
  input wire logic [31:0] pay_data,
  input wire logic [3:0] pay_be,
  input wire logic pay_valid
);
  logic [1:0] wcnt_r;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (sys_rst);
  // Saturates at 3: only the very first buffer is judged
  always_ff @(posedge clk_sys) begin
    if (sys_rst) wcnt_r <= 2'h0;
    else if (wvalid && wcnt_r != 2'h3) wcnt_r <= wcnt_r + 2'h1;
  end
  word_taken_a: assert property (wready) else $error("word refused");
  cmd_first_a: assert property (pay_valid |-> wcnt_r == 2'h3) else $error("payload before commands");
  pay_cause_a: assert property (pay_valid |-> $past(wvalid)) else $error("payload without word");
  be_lanes_a: assert property (pay_valid |-> pay_be inside
    {4'h1, 4'h3, 4'h7, 4'hf, 4'h2, 4'h6, 4'he, 4'h4, 4'hc, 4'h8}) else $error("bad lanes");
  irq_done_a: assert property (irq |-> buf_done) else $error("irq without done");
  done_cause_a: assert property ($rose(buf_done) |-> $past(wvalid)) else $error("done without word");
  err_cause_a: assert property ($rose(tx_error) |-> $past(wvalid)) else $error("error without word");
  stat_cause_a: assert property (stat_valid |-> $past(wvalid)) else $error("status without word");
  cover property (pay_valid && pay_be == 4'he);
  cover property ($rose(tx_error));
  cover property ($rose(irq));
endmodule

// ---- dv/tx_command_word_decoder_test.sv ----
`timescale 1ns/1ps
module tx_command_word_decoder_test;
  logic clk_sys = 1'b0;
  logic sys_rst = 1'b1;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hwrite = 1'b0, hsel = 1'b0, hreadyout, hresp, en, dclr, eclr;
  logic [7:0] be_log = 8'h0;
  logic [31:0] last_pay = 32'h0;
  int fail_count = 0, num_checks = 0, pay_n = 0, p;
  tcd_if link ();
  tcd_host i_tcd_host (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hsel(hsel), .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .done_irq_en(en), .done_clr(dclr), .err_clr(eclr));
  tcd_device i_tcd_device (.clk_sys(clk_sys), .sys_rst(sys_rst), .link(link), .done_irq_en(en),
    .done_clr(dclr), .err_clr(eclr));
  tcd_check_sva i_tcd_check_sva (.clk_sys(clk_sys), .sys_rst(sys_rst), .wdata(link.wdata),
    .wvalid(link.wvalid), .wready(link.wready), .tx_error(link.tx_error), .buf_done(link.buf_done),
    .irq(link.irq), .stat_valid(link.stat_valid), .stat_tag(link.stat_tag), .pay_data(link.pay_data),
    .pay_be(link.pay_be), .pay_valid(link.pay_valid));
  always #4 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (link.pay_valid === 1'b1) begin
      pay_n++;
      be_log <= {be_log[3:0], link.pay_be};
      last_pay <= link.pay_data;
    end
  end
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("[ERR] t=%0t seen %h exp %h", $time, seen, exp);
    end
  endtask
  task automatic wt();
    int n;
    n = 0;
    @(posedge clk_sys);
    while (hreadyout !== 1'b1) begin
      n++;
      if (n > 50) begin
        fail_count++;
        print_verdict();
      end
      @(posedge clk_sys);
    end
  endtask
  task automatic xfer(logic w, logic [7:0] a, logic [31:0] d);
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= 2'h2;
    hsel <= 1'b1;
    wt();
    htrans <= 2'h0;
    hwdata <= d;
    wt();
    rd = hrdata;
  endtask
  // Idle first so the word's effect has landed in the flags
  task automatic rchk(logic [7:0] a, logic [31:0] exp);
    repeat (3) @(posedge clk_sys);
    xfer(1'b0, a, 32'h0);
    chk(rd, exp);
  endtask
  function automatic logic [31:0] cmda(logic ioc, logic [1:0] al, logic [4:0] ofs, logic [1:0] fl, int sz);
    return {ioc, 5'h0, al, 3'h0, ofs, 2'h0, fl, 1'b0, 11'(sz)};
  endfunction
  task automatic send(logic [31:0] a, logic [31:0] b, int n);
    xfer(1'b1, tcd_pkg::REG_DATA, a);
    xfer(1'b1, tcd_pkg::REG_DATA, b);
    for (int i = 0; i < n; i++) xfer(1'b1, tcd_pkg::REG_DATA, {8{4'(i)}});
  endtask
  initial begin
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    rchk(tcd_pkg::REG_STATUS, 32'h0);
    rchk(tcd_pkg::REG_CTRL, tcd_pkg::CTRL_RST);
    $display("test reset done");
    send(cmda(1'b1, tcd_pkg::ALIGN_4, 5'h1, 2'h3, 6), {16'h1234, 16'h6}, 2);
    rchk(tcd_pkg::REG_STATUS, 32'h2);
    chk(be_log, 8'he7);
    chk(pay_n, 2);
    chk(last_pay, 32'h1111_1111);
    chk(hresp, 1'b0);
    rchk(tcd_pkg::REG_TAG, 32'h1234);
    chk(link.irq, 1'b0);
    xfer(1'b1, tcd_pkg::REG_CTRL, 32'h1);
    rchk(tcd_pkg::REG_CTRL, 32'h1);
    chk(link.irq, 1'b1);
    xfer(1'b1, tcd_pkg::REG_STATUS, 32'h2);
    rchk(tcd_pkg::REG_STATUS, 32'h0);
    chk(link.irq, 1'b0);
    $display("test done flag done");
    // Padding words must vanish and the next command parse cleanly
    for (int al = 0; al < 3; al++) begin
      p = pay_n;
      send(cmda(1'b0, 2'(al), 5'h0, 2'h3, 4), 32'h4, al == 0 ? 1 : 4 << (al - 1));
      rchk(tcd_pkg::REG_STATUS, 32'h0);
      chk(pay_n - p, 1);
    end
    $display("test alignment done");
    send(cmda(1'b0, 2'h0, 5'h0, 2'h2, 4), {16'h5, 16'h8}, 1);
    send(cmda(1'b0, 2'h0, 5'h0, 2'h1, 4), {16'h6, 16'h8}, 1);
    rchk(tcd_pkg::REG_STATUS, 32'h1);
    xfer(1'b1, tcd_pkg::REG_STATUS, 32'h1);
    rchk(tcd_pkg::REG_STATUS, 32'h0);
    send(cmda(1'b0, 2'h0, 5'h0, 2'h3, 4), {16'h7, 16'h8}, 1);
    rchk(tcd_pkg::REG_STATUS, 32'h1);
    $display("test error done");
    print_verdict();
  end
endmodule
